//--- hw/i2c_flags_pkg.sv
package i2c_flags_pkg;

   // ****************************************
   // Register map, byte addresses
   // ****************************************
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SLAVE_ADDR = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_SECOND_ADDR = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_BUS_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_BUS_DATA = 5'h10;

   // ****************************************
   // Control register fields
   // ****************************************
   localparam int CTRL_W = 5;
   localparam int CTRL_MASTER_BIT = 0;
   localparam int CTRL_TRANSMIT_BIT = 1;
   localparam int CTRL_ARB_SEL_BIT = 2;
   localparam int CTRL_FS_BIT = 3;
   localparam int CTRL_FSX_BIT = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

   // ****************************************
   // Status register fields
   // ****************************************
   localparam int FLAG_N = 4;
   localparam int FLAG_LSB = 1;
   localparam int IDX_GC = 0;
   localparam int IDX_AAS = 1;
   localparam int IDX_AL = 2;
   localparam int IDX_SECOND_ADDR_MATCH_FLAG = 3;
   localparam logic [FLAG_N-1:0] FLAGS_RESET = 4'h0;

   // ****************************************
   // Bus constants
   // ****************************************
   localparam int SADDR_W = 7;
   localparam logic [SADDR_W-1:0] SADDR_RESET = 7'h00;
   localparam logic [7:0] GENERAL_CALL = 8'h00;
   localparam logic [3:0] FRAME_LAST = 4'h7;
   localparam logic [7:0] DATA_RESET = 8'h00;

endpackage : i2c_flags_pkg

//--- hw/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
   parameter int W = 1
) (
   input wire logic clock, // Destination clock
   input wire logic nrst, // Async reset, active low
   input wire logic [W-1:0] din, // Asynchronous input
   output logic [W-1:0] dout // Synchronised output
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t s_reg;
   sync_state_t s_next;

   always_comb begin
      s_next.meta = din;
      s_next.stable = s_reg.meta;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dout = s_reg.stable;
endmodule : bit_sync

//--- hw/toggle_pulse.sv
`timescale 1ns/1ps
module toggle_pulse (
   input wire logic clock, // Destination clock
   input wire logic nrst, // Async reset, active low
   input wire logic toggle_in, // Toggle from the other domain
   output logic pulse // One-cycle pulse per toggle
);
   typedef struct packed {
      logic prev;
      logic pulse;
   } edge_state_t;

   edge_state_t s_reg;
   edge_state_t s_next;
   logic toggle_s;

   bit_sync #(.W(1)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .din(toggle_in),
      .dout(toggle_s)
   );

   always_comb begin
      s_next.prev = toggle_s;
      s_next.pulse = toggle_s ^ s_reg.prev;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pulse = s_reg.pulse;
endmodule : toggle_pulse

//--- hw/i2c_address_arbitration_flags.sv
// Operation
// - Second address match sets second match flag
// - Second flag cleared: read-write0, start, master
// - SDA mismatch at SCL rise loses arbitration
// - Select 0: SCL high at fall loses
// - Select 1: early foreign SDA low loses
// - Arbitration flag cleared by data access, write0
// - Own address or general call sets match
// - Match flag cleared: data access, write0, master
// - General call sets call flag unless both formats 1
// - Call flag cleared: data access, write0, master
// - First format 1: no match; call flag only if second format 0
`timescale 1ns/1ps
module i2c_address_arbitration_flags
   import i2c_flags_pkg::*;
(
   input wire logic clock, // System clock, 100 MHz
   input wire logic nrst, // Async reset, active low
   input wire logic [ADDR_W-1:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall, high until answer
   input wire logic link_clock, // Link sampling clock
   input wire logic scl_in, // SCL pin level
   input wire logic sda_in, // SDA pin level
   input wire logic int_scl, // Own SCL drive, 1 = released (link domain)
   input wire logic int_sda, // Own SDA drive, 1 = released (link domain)
   input wire logic start_issue // Start instruction executed, pulse (link domain)
);

   // ****************************************
   // System domain state
   // ****************************************
   typedef struct packed {
      logic waiting;
      logic [31:0] rdata;
      logic [CTRL_W-1:0] ctrl;
      logic [SADDR_W-1:0] saddr;
      logic [SADDR_W-1:0] saddr2;
      logic [FLAG_N-1:0] flags;
      logic [FLAG_N-1:0] seen;
      logic [7:0] data;
   } sys_state_t;

   // ****************************************
   // Link domain state
   // ****************************************
   typedef struct packed {
      logic scl_d;
      logic sda_d;
      logic in_frame;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] frame;
      logic armed;
      logic t_start;
      logic t_frame;
      logic t_arb;
   } link_state_t;

   sys_state_t s_reg;
   sys_state_t s_next;
   link_state_t l_reg;
   link_state_t l_next;

   logic scl_s;
   logic sda_s;
   logic [2:0] cfg_s;
   logic start_pulse;
   logic frame_pulse;
   logic arb_pulse;

   // ****************************************
   // Crossings
   // ****************************************
   bit_sync #(.W(2)) u_pin_sync (
      .clock(link_clock),
      .nrst(nrst),
      .din({scl_in, sda_in}),
      .dout({scl_s, sda_s})
   );

   bit_sync #(.W(3)) u_cfg_sync (
      .clock(link_clock),
      .nrst(nrst),
      .din({s_reg.ctrl[CTRL_ARB_SEL_BIT], s_reg.ctrl[CTRL_TRANSMIT_BIT], s_reg.ctrl[CTRL_MASTER_BIT]}),
      .dout(cfg_s)
   );

   toggle_pulse u_start_cross (
      .clock(clock),
      .nrst(nrst),
      .toggle_in(l_reg.t_start),
      .pulse(start_pulse)
   );

   toggle_pulse u_frame_cross (
      .clock(clock),
      .nrst(nrst),
      .toggle_in(l_reg.t_frame),
      .pulse(frame_pulse)
   );

   toggle_pulse u_arb_cross (
      .clock(clock),
      .nrst(nrst),
      .toggle_in(l_reg.t_arb),
      .pulse(arb_pulse)
   );

   // ****************************************
   // Link side: start, first frame, arbitration
   // ****************************************
   always_comb begin
      logic l_master;
      logic l_tx;
      logic l_sel;
      logic scl_rise;
      logic scl_fall;
      logic start_det;
      logic stop_det;
      logic arb_ev;
      l_master = cfg_s[0];
      l_tx = cfg_s[1];
      l_sel = cfg_s[2];
      scl_rise = scl_s && !l_reg.scl_d;
      scl_fall = !scl_s && l_reg.scl_d;
      start_det = scl_s && l_reg.scl_d && l_reg.sda_d && !sda_s;
      stop_det = scl_s && l_reg.scl_d && !l_reg.sda_d && sda_s;
      l_next = l_reg;
      l_next.scl_d = scl_s;
      l_next.sda_d = sda_s;

      // ****************************************
      // Start, stop and first frame capture
      // ****************************************
      if (start_det) begin
         l_next.in_frame = 1'b1;
         l_next.cnt = '0;
         l_next.t_start = !l_reg.t_start;
      end else if (stop_det) begin
         l_next.in_frame = 1'b0;
      end else if (scl_rise && l_reg.in_frame) begin
         l_next.shreg = {l_reg.shreg[6:0], sda_s};
         l_next.cnt = 4'(l_reg.cnt + 4'h1);
         if (l_reg.cnt == FRAME_LAST) begin
            // Only the first frame after a start is an address frame
            l_next.frame = {l_reg.shreg[6:0], sda_s};
            l_next.in_frame = 1'b0;
            l_next.t_frame = !l_reg.t_frame;
         end
      end

      // ****************************************
      // Arbitration watch
      // ****************************************
      arb_ev = 1'b0;
      if (l_master && l_tx && scl_rise && (int_sda != sda_s)) begin
         arb_ev = 1'b1;
      end
      if (!l_sel && l_master && scl_fall && int_scl) begin
         arb_ev = 1'b1;
      end
      if (l_sel && l_reg.armed && !sda_s && int_sda) begin
         arb_ev = 1'b1;
      end
      if (start_issue && l_master && l_tx && l_sel) begin
         l_next.armed = 1'b1;
      end else if (!int_sda || arb_ev || !l_master) begin
         l_next.armed = 1'b0;
      end
      if (arb_ev) begin
         l_next.t_arb = !l_reg.t_arb;
      end
   end

   always_ff @(posedge link_clock or negedge nrst) begin
      if (!nrst) begin
         l_reg <= '{scl_d: 1'b1, sda_d: 1'b1, default: '0};
      end else begin
         l_reg <= l_next;
      end
   end

   // ****************************************
   // System side: bus slave and flags
   // ****************************************
   always_comb begin
      logic master;
      logic tx;
      logic slave_rx;
      logic fs;
      logic second_format_select;
      logic take;
      logic wr_lane;
      logic data_clear;
      logic gc;
      logic own_hit;
      logic second_hit;
      logic [FLAG_N-1:0] clr;
      logic [FLAG_N-1:0] set;
      logic [31:0] rd_mux;
      master = s_reg.ctrl[CTRL_MASTER_BIT];
      tx = s_reg.ctrl[CTRL_TRANSMIT_BIT];
      fs = s_reg.ctrl[CTRL_FS_BIT];
      second_format_select = s_reg.ctrl[CTRL_FSX_BIT];
      gc = (l_reg.frame == GENERAL_CALL);
      own_hit = (l_reg.frame[7:1] == s_reg.saddr);
      second_hit = (l_reg.frame[7:1] == s_reg.saddr2);
      slave_rx = !master && !tx;
      take = !s_reg.waiting && (avs_read || avs_write);
      wr_lane = take && avs_write && avs_byteenable[0];
      clr = '0;
      set = '0;
      s_next = s_reg;

      // ****************************************
      // Read mux
      // ****************************************
      rd_mux = '0;
      unique case (avs_address)
         OFS_CTRL: rd_mux[CTRL_W-1:0] = s_reg.ctrl;
         OFS_SLAVE_ADDR: rd_mux[SADDR_W-1:0] = s_reg.saddr;
         OFS_SECOND_ADDR: rd_mux[SADDR_W-1:0] = s_reg.saddr2;
         OFS_BUS_STATUS: rd_mux[FLAG_LSB +: FLAG_N] = s_reg.flags;
         OFS_BUS_DATA: rd_mux[7:0] = s_reg.data;
         default: rd_mux = '0;
      endcase

      // ****************************************
      // Bus answer
      // ****************************************
      // Every request is answered in the cycle after it is seen
      if (s_reg.waiting && (avs_read || avs_write)) begin
         s_next.waiting = 1'b0;
         s_next.rdata = avs_read ? rd_mux : '0;
      end else begin
         s_next.waiting = 1'b1;
         s_next.rdata = '0;
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (wr_lane) begin
         unique case (avs_address)
            OFS_CTRL: s_next.ctrl = avs_writedata[CTRL_W-1:0];
            OFS_SLAVE_ADDR: s_next.saddr = avs_writedata[SADDR_W-1:0];
            OFS_SECOND_ADDR: s_next.saddr2 = avs_writedata[SADDR_W-1:0];
            OFS_BUS_DATA: s_next.data = avs_writedata[7:0];
            OFS_BUS_STATUS: clr = s_reg.seen & ~avs_writedata[FLAG_LSB +: FLAG_N];
            default: clr = '0;
         endcase
      end
      if (take && avs_read && avs_address == OFS_BUS_STATUS) begin
         // Arm only what the master actually takes on this edge
         s_next.seen = s_reg.seen | s_reg.rdata[FLAG_LSB +: FLAG_N];
      end

      // ****************************************
      // Flag clears
      // ****************************************
      data_clear = take && (avs_address == OFS_BUS_DATA) && ((avs_write && tx) || (avs_read && !tx));
      if (data_clear) begin
         clr[IDX_AL] = 1'b1;
         clr[IDX_AAS] = 1'b1;
         clr[IDX_GC] = 1'b1;
      end
      if (start_pulse || master) begin
         clr[IDX_SECOND_ADDR_MATCH_FLAG] = 1'b1;
      end
      if (master) begin
         clr[IDX_AAS] = 1'b1;
         clr[IDX_GC] = 1'b1;
      end

      // ****************************************
      // Flag sets
      // ****************************************
      if (frame_pulse && slave_rx) begin
         // Frame byte is stable in the link domain long after its toggle
         set[IDX_SECOND_ADDR_MATCH_FLAG] = !second_format_select && second_hit;
         set[IDX_AAS] = !fs && (own_hit || gc);
         set[IDX_GC] = gc && (!fs || !second_format_select);
      end
      set[IDX_AL] = arb_pulse;

      // A new event wins over a clear in the same cycle
      s_next.flags = (s_reg.flags & ~clr) | set;
      s_next.seen = s_next.seen & ~clr & ~set;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '{waiting: 1'b1, rdata: '0, ctrl: CTRL_RESET, saddr: SADDR_RESET, saddr2: SADDR_RESET,
                    flags: FLAGS_RESET, seen: FLAGS_RESET, data: DATA_RESET};
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_readdata = s_reg.rdata;
   assign avs_waitrequest = s_reg.waiting;
endmodule : i2c_address_arbitration_flags

//--- tb/i2c_flags_monitor.sv
`timescale 1ns/1ps
module i2c_flags_monitor
   import i2c_flags_pkg::*;
(
   input wire logic clock, // Clock
   input wire logic nrst, // Reset
   input wire logic [ADDR_W-1:0] avs_address, // Address
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Lanes
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest // Stall
);
   // ****
   // Master bit tracked from control writes
   // ****
   logic master_reg;
   logic req;
   logic st_rd;
   assign req = avs_read | avs_write;
   assign st_rd = avs_read & avs_waitrequest & (avs_address == OFS_BUS_STATUS);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         master_reg <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_byteenable[0]) begin
         master_reg <= avs_writedata[CTRL_MASTER_BIT];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_ans; req && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("answer late");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer too long");
   property p_cause; !avs_waitrequest |-> $past(req); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_rd0; avs_waitrequest |-> avs_readdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("read data while stalled");
   property p_wr0; avs_write && avs_waitrequest |=> avs_readdata == 32'h0; endproperty
   a_wr0: assert property (p_wr0) else $error("read data on write");
   property p_unm; avs_read && avs_waitrequest && avs_address > OFS_BUS_DATA |=> avs_readdata == 32'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_resv; st_rd |=> avs_readdata[31:5] == 27'h0 && avs_readdata[0] == 1'b0; endproperty
   a_resv: assert property (p_resv) else $error("spare status bits set");
   property p_mst; st_rd && master_reg |=> (avs_readdata[4:1] & 4'hB) == 4'h0; endproperty
   a_mst: assert property (p_mst) else $error("match flags set in master mode");
   c_unm: cover property (avs_read && !avs_waitrequest && avs_address > OFS_BUS_DATA);
   c_mst: cover property (st_rd && master_reg);
   c_wst: cover property (avs_write && !avs_waitrequest && avs_address == OFS_BUS_STATUS);
endmodule : i2c_flags_monitor

bind i2c_address_arbitration_flags i2c_flags_monitor u_mon (.clock(clock), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

//--- tb/i2c_bus_partner.sv
`timescale 1ns/1ps
module i2c_bus_partner (
   input wire logic link_clock, // Link clock
   output logic scl_o, // SCL drive, 1 = released
   output logic sda_o // SDA drive, 1 = released
);
   // ****
   // Other bus party, open drain with pull-up
   // ****
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic step(input logic c, input logic d);
      @(posedge link_clock);
      scl_o <= c;
      sda_o <= d;
   endtask : step
   task automatic frame(input logic [7:0] b);
      step(1'b1, 1'b0); // Start
      for (int i = 7; i >= 0; i--) begin
         step(1'b0, b[i]);
         step(1'b1, b[i]);
      end
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1); // Stop
   endtask : frame
endmodule : i2c_bus_partner

//--- tb/tb_i2c_address_arbitration_flags.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_i2c_address_arbitration_flags;
   import i2c_flags_pkg::*;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic int_scl = 1'b1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic int_sda = 1'b1;
   logic start_issue = 1'b0;
   logic p_scl;
   logic p_sda;
   int miscompares = 0;
   int n_checks = 0;
   always #5 clock = ~clock;
   initial #7 forever #24 link_clock = ~link_clock;
   i2c_bus_partner partner (.link_clock(link_clock), .scl_o(p_scl), .sda_o(p_sda));
   i2c_address_arbitration_flags DUT (.clock(clock), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_clock(link_clock),
      .scl_in(p_scl), .sda_in(p_sda & int_sda), .int_scl(int_scl), .int_sda(int_sda), .start_issue(start_issue));
   // ****
   // Bus access and scenarios
   // ****
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic st(input logic [7:0] e);
      logic [31:0] q;
      repeat (6) @(posedge link_clock);
      bus(1'b0, OFS_BUS_STATUS, 8'h00, q);
      `CHK("status", {24'h0, e}, q)
   endtask : st
   task automatic clk_bit(input logic d);
      partner.step(1'b0, 1'b1);
      partner.step(1'b0, d);
      partner.step(1'b1, d);
      partner.step(1'b0, 1'b1);
      partner.step(1'b1, 1'b1);
   endtask : clk_bit
   task automatic t_match;
      logic [31:0] q;
      st(8'h00);
      bus(1'b0, 5'h1C, 8'h00, q);
      `CHK("unmapped", 32'h0, q)
      wr(OFS_SLAVE_ADDR, 8'h2A);
      wr(OFS_SECOND_ADDR, 8'h15);
      avs_byteenable <= 4'hE;
      wr(OFS_SLAVE_ADDR, 8'h33);
      avs_byteenable <= 4'hF;
      bus(1'b0, OFS_SLAVE_ADDR, 8'h00, q);
      `CHK("slave address", 32'h2A, q)
      partner.frame(8'h54);
      wr(OFS_BUS_STATUS, 8'h00);
      st(8'h04);
      wr(OFS_BUS_STATUS, 8'hFF);
      st(8'h04);
      wr(OFS_BUS_STATUS, 8'h00);
      st(8'h00);
      partner.frame(8'h2B);
      st(8'h10);
      partner.frame(8'hFE);
      st(8'h00);
      wr(OFS_CTRL, 8'h10);
      partner.frame(8'h2A);
      st(8'h00);
      $display("t_match done");
   endtask : t_match
   task automatic t_gc;
      logic [31:0] q;
      wr(OFS_CTRL, 8'h08);
      partner.frame(8'h00);
      st(8'h02);
      bus(1'b0, OFS_BUS_DATA, 8'h00, q);
      st(8'h00);
      wr(OFS_CTRL, 8'h00);
      partner.frame(8'h00);
      st(8'h06);
      wr(OFS_CTRL, 8'h01);
      st(8'h00);
      $display("t_gc done");
   endtask : t_gc
   task automatic t_arb;
      logic [31:0] q;
      wr(OFS_CTRL, 8'h07);
      clk_bit(1'b0);
      st(8'h08);
      bus(1'b0, OFS_BUS_DATA, 8'h00, q);
      `CHK("data reset", {24'h0, DATA_RESET}, q)
      st(8'h08);
      wr(OFS_BUS_DATA, 8'h5A);
      st(8'h00);
      bus(1'b0, OFS_BUS_DATA, 8'h00, q);
      `CHK("data", 32'h5A, q)
      wr(OFS_CTRL, 8'h01);
      clk_bit(1'b1);
      st(8'h08);
      wr(OFS_BUS_STATUS, 8'h00);
      st(8'h00);
      @(posedge link_clock);
      int_scl <= 1'b0;
      clk_bit(1'b1);
      st(8'h00);
      int_scl <= 1'b1;
      wr(OFS_CTRL, 8'h07);
      // Let the mode bits cross into the link domain first
      repeat (3) @(posedge link_clock);
      start_issue <= 1'b1;
      @(posedge link_clock);
      start_issue <= 1'b0;
      partner.step(1'b1, 1'b0);
      st(8'h08);
      partner.step(1'b1, 1'b1);
      $display("t_arb done");
   endtask : t_arb
   task automatic summarize;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      t_match;
      t_gc;
      t_arb;
      summarize;
   end
   initial begin
      #200000;
      miscompares++;
      summarize;
   end
endmodule : tb_i2c_address_arbitration_flags
